// >>> rtl/multi_mode_counter_config.sv
// four-channel counter core with stored and active communication settings
`timescale 1ns/1ps
module multi_mode_counter_config #(
  parameter int MODULE_WD_CYCLES = mmc_pkg::MODULE_WD_CYCLES,
  parameter int COMM_TICK_CYCLES = mmc_pkg::COMM_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // power-on straps
  input wire logic init_n,
  input wire logic init_switch,
  input wire logic factory_load,
  // decoded configuration commands
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_data,
  output logic cfg_ack,
  output logic cfg_err,
  output mmc_pkg::stored_cfg_s stored_cfg,
  // active communication settings, and report style from the stored format
  output mmc_pkg::comm_cfg_s active_cfg,
  output logic init_mode,
  output logic parity_en,
  output logic parity_odd,
  output logic two_stop,
  output logic baud_tick,
  output logic report_hex,
  // counter inputs and readback
  input wire logic [3:0] channel_a_input,
  input wire logic [3:0] channel_b_input,
  input wire logic [3:0] count_clear,
  input wire logic rd_req,
  input wire logic [1:0] rd_chan,
  output logic rd_valid,
  output logic [31:0] rd_data,
  // watchdogs
  input wire logic module_wd_kick,
  output logic module_wd_bark,
  input wire logic comm_activity,
  output logic comm_wd_expired,
  // checksum
  input wire logic chk_clear,
  input wire logic chk_valid,
  input wire logic [7:0] chk_char,
  output logic [7:0] chk_sum,
  output logic [7:0] chk_hi_char,
  output logic [7:0] chk_lo_char
);

  // baud code to clock cycles per oversample tick
  function automatic logic [15:0] baud_div(input logic [5:0] code);
    int rate;
    case (code)
      6'h03: rate = 1200;
      6'h04: rate = 2400;
      6'h05: rate = 4800;
      6'h06: rate = 9600;
      6'h07: rate = 19200;
      6'h08: rate = 38400;
      6'h09: rate = 57600;
      6'h0a: rate = 115200;
      default: rate = 9600;
    endcase
    return 16'(mmc_pkg::CLK_HZ / (mmc_pkg::BAUD_OVERSAMPLE * rate));
  endfunction

  // one counting step for a channel
  function automatic logic [31:0] count_step(input logic [7:0] ttype, input logic [31:0] cnt,
                                             input logic fa, input logic fb, input logic ra,
                                             input logic bl);
    logic [31:0] r;
    r = cnt;
    case (ttype)
      mmc_pkg::TYPE_UP, mmc_pkg::TYPE_FREQ: if (fa) r = cnt + 32'h1;
      mmc_pkg::TYPE_UPDOWN: begin
        if (fa && !fb) r = cnt + 32'h1;
        else if (fb && !fa) r = cnt - 32'h1;
      end
      mmc_pkg::TYPE_PDIR: if (fa) r = bl ? cnt + 32'h1 : cnt - 32'h1;
      mmc_pkg::TYPE_QUAD: if (ra) r = bl ? cnt - 32'h1 : cnt + 32'h1;
      default: r = cnt;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic type_valid(input logic [7:0] t);
    return t == mmc_pkg::TYPE_UP || t == mmc_pkg::TYPE_FREQ || t == mmc_pkg::TYPE_UPDOWN ||
           t == mmc_pkg::TYPE_PDIR || t == mmc_pkg::TYPE_QUAD;
  endfunction

  logic cfg_ok;
  logic boot;
  logic [15:0] baud_cnt;
  logic [3:0] a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  logic [3:0] fall_a, fall_b, rise_a;
  logic [31:0] count [4];
  logic [31:0] wd_cnt;
  logic [31:0] tick_cnt;
  logic [7:0] comm_cnt;
  logic [7:0] next_sum;
  mmc_pkg::output_format_s fmt_in;

  assign fmt_in = mmc_pkg::output_format_s'(cfg_data);

  // validity of a configuration write; rejected writes leave the store untouched
  always_comb begin
    case (cfg_sel)
      mmc_pkg::SEL_ADDR, mmc_pkg::SEL_COIL, mmc_pkg::SEL_COMM_WD: cfg_ok = 1'b1;
      mmc_pkg::SEL_LINE: cfg_ok = cfg_data[5:0] >= mmc_pkg::BAUD_MIN &&
                                  cfg_data[5:0] <= mmc_pkg::BAUD_MAX;
      mmc_pkg::SEL_FORMAT: cfg_ok = !fmt_in.rsv_hi && fmt_in.rsv_lo == 4'h0 &&
        (fmt_in.report_format_field == mmc_pkg::REPORT_HEX ||
         (fmt_in.report_format_field == mmc_pkg::REPORT_ENG &&
          stored_cfg.input_type_code == mmc_pkg::TYPE_FREQ));
      mmc_pkg::SEL_TYPE: cfg_ok = type_valid(cfg_data) &&
        (stored_cfg.output_format_byte.report_format_field != mmc_pkg::REPORT_ENG ||
         cfg_data == mmc_pkg::TYPE_FREQ);
      mmc_pkg::SEL_PROTO: cfg_ok = init_mode && cfg_data <= 8'h01;
      default: cfg_ok = 1'b0;
    endcase
  end

  // stored settings survive a plain reset; factory_load during reset restores defaults
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      if (factory_load) begin
        stored_cfg.addr <= mmc_pkg::DEFAULT_ADDR;
        stored_cfg.line_setting_byte <= mmc_pkg::DEFAULT_LINE;
        stored_cfg.output_format_byte <= mmc_pkg::DEFAULT_FORMAT;
        stored_cfg.input_type_code <= mmc_pkg::TYPE_UP;
        stored_cfg.modbus <= 1'b1;
        stored_cfg.comm_wd <= mmc_pkg::DEFAULT_COMM_WD;
      end
    end else if (cfg_wr && cfg_ok) begin
      case (cfg_sel)
        mmc_pkg::SEL_ADDR: stored_cfg.addr <= cfg_data;
        mmc_pkg::SEL_LINE: stored_cfg.line_setting_byte <= cfg_data;
        mmc_pkg::SEL_FORMAT: stored_cfg.output_format_byte <= cfg_data;
        mmc_pkg::SEL_TYPE: stored_cfg.input_type_code <= cfg_data;
        mmc_pkg::SEL_COIL: stored_cfg.modbus <= cfg_data[0];
        mmc_pkg::SEL_PROTO: stored_cfg.modbus <= cfg_data[0];
        mmc_pkg::SEL_COMM_WD: stored_cfg.comm_wd <= cfg_data;
        default: stored_cfg.addr <= stored_cfg.addr;
      endcase
    end
  end

  // command answer pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_ack <= 1'b0;
      cfg_err <= 1'b0;
    end else begin
      cfg_ack <= cfg_wr && cfg_ok;
      cfg_err <= cfg_wr && !cfg_ok;
    end
  end

  // active settings load once after reset release, so address, line, checksum and protocol writes wait for the next power-on
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot <= 1'b1;
      init_mode <= 1'b0;
      active_cfg <= '{addr: mmc_pkg::DEFAULT_ADDR, line: mmc_pkg::DEFAULT_LINE, cs: 1'b0,
                      modbus: 1'b1};
    end else if (boot) begin
      boot <= 1'b0;
      init_mode <= !init_n || init_switch;
      if (!init_n || init_switch) begin
        active_cfg <= '{addr: mmc_pkg::INIT_ADDR, line: '{char_fmt: mmc_pkg::FMT_NONE_ONE,
                        baud: mmc_pkg::BAUD_9600}, cs: 1'b0, modbus: 1'b0};
      end else begin
        active_cfg <= '{addr: stored_cfg.addr, line: stored_cfg.line_setting_byte,
                        cs: stored_cfg.output_format_byte.cs,
                        modbus: stored_cfg.modbus};
      end
    end
  end

  // character format and report style decoded into flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      parity_en <= 1'b0;
      parity_odd <= 1'b0;
      two_stop <= 1'b0;
      report_hex <= 1'b1;
    end else begin
      parity_en <= active_cfg.line.char_fmt[1];
      parity_odd <= active_cfg.line.char_fmt == mmc_pkg::FMT_ODD_ONE;
      two_stop <= active_cfg.line.char_fmt == mmc_pkg::FMT_NONE_TWO;
      report_hex <= stored_cfg.output_format_byte.report_format_field ==
                    mmc_pkg::REPORT_HEX;
    end
  end

  // oversample tick divider for the serial link
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      baud_cnt <= 16'h0;
      baud_tick <= 1'b0;
    end else if (baud_cnt >= baud_div(active_cfg.line.baud) - 16'h1) begin
      baud_cnt <= 16'h0;
      baud_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h1;
      baud_tick <= 1'b0;
    end
  end

  // two-flop synchronisers plus a history stage for edges; a glitch under 8 ns is lost unless it spans a rising clk_sys edge
  // no reset: the chain tracks the pins during reset, so a low pin gives no false edge
  always_ff @(posedge clk_sys) begin
    a_s1 <= channel_a_input;
    a_s2 <= a_s1;
    a_s3 <= a_s2;
    b_s1 <= channel_b_input;
    b_s2 <= b_s1;
    b_s3 <= b_s2;
  end

  assign fall_a = a_s3 & ~a_s2;
  assign fall_b = b_s3 & ~b_s2;
  assign rise_a = ~a_s3 & a_s2;

  // per-channel counters; clear beats a same-cycle count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < mmc_pkg::NUM_CH; i++) count[i] <= 32'h0;
    end else begin
      for (int i = 0; i < mmc_pkg::NUM_CH; i++) begin
        if (count_clear[i]) count[i] <= 32'h0;
        else count[i] <= count_step(stored_cfg.input_type_code, count[i], fall_a[i],
                                    fall_b[i], rise_a[i], b_s2[i]);
      end
    end
  end

  // channel readback, answered one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) rd_data <= count[rd_chan];
    end
  end

  // fixed module watchdog, restarted by every kick
  always_ff @(posedge clk_sys) begin
    if (!rst_n || module_wd_kick) begin
      wd_cnt <= 32'h0;
      module_wd_bark <= 1'b0;
    end else if (wd_cnt >= 32'(MODULE_WD_CYCLES - 1)) begin
      wd_cnt <= 32'h0;
      module_wd_bark <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 32'h1;
      module_wd_bark <= 1'b0;
    end
  end

  // communication watchdog in 100 ms steps; zero timeout disables it
  always_ff @(posedge clk_sys) begin
    if (!rst_n || comm_activity) begin
      tick_cnt <= 32'h0;
      comm_cnt <= 8'h0;
      comm_wd_expired <= 1'b0;
    end else begin
      if (tick_cnt >= 32'(COMM_TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0;
        if (comm_cnt != 8'hff) comm_cnt <= comm_cnt + 8'h1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
      if (stored_cfg.comm_wd != 8'h0 && comm_cnt >= stored_cfg.comm_wd)
        comm_wd_expired <= 1'b1;
    end
  end

  // running checksum; a clear with a character restarts the sum at that character
  always_comb begin
    next_sum = chk_clear ? 8'h0 : chk_sum;
    if (chk_valid) next_sum = next_sum + chk_char;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chk_sum <= 8'h0;
      chk_hi_char <= 8'h30;
      chk_lo_char <= 8'h30;
    end else begin
      chk_sum <= next_sum;
      chk_hi_char <= hex_char(next_sum[7:4]);
      chk_lo_char <= hex_char(next_sum[3:0]);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence up_only_fall(int i);
    fall_a[i] && !fall_b[i] && !count_clear[i];
  endsequence

  init_settings_a: assert property (init_mode |-> active_cfg.addr == 8'h00 &&
    !active_cfg.cs && !active_cfg.modbus && active_cfg.line.baud == 6'h06)
    else $error("init settings wrong");
  baud_reject_a: assert property (cfg_wr && cfg_sel == mmc_pkg::SEL_LINE &&
    cfg_data[5:0] > 6'h0a |=> cfg_err && $stable(stored_cfg.line_setting_byte))
    else $error("bad baud kept");
  eng_freq_a: assert property (stored_cfg.output_format_byte.report_format_field == 2'h0
    |-> stored_cfg.input_type_code == 8'h51) else $error("eng format on non-freq");
  updown_a: assert property ((stored_cfg.input_type_code == 8'h54) and up_only_fall(0)
    |=> count[0] == $past(count[0]) + 32'h1) else $error("up/down miscount");
  pdir_a: assert property (stored_cfg.input_type_code == 8'h55 && fall_a[1] &&
    !b_s2[1] && !count_clear[1] |=> count[1] == $past(count[1]) - 32'h1)
    else $error("pdir miscount");
  quad_a: assert property (stored_cfg.input_type_code == 8'h56 && rise_a[2] &&
    !b_s2[2] && !count_clear[2] |=> count[2] == $past(count[2]) + 32'h1)
    else $error("quad miscount");
  proto_guard_a: assert property (cfg_wr && cfg_sel == mmc_pkg::SEL_PROTO && !init_mode
    |=> cfg_err && $stable(stored_cfg.modbus)) else $error("protocol set outside init");
  coil_defer_a: assert property (cfg_wr && cfg_sel == mmc_pkg::SEL_COIL && !cfg_data[0]
    |=> !stored_cfg.modbus && $stable(active_cfg)) else $error("coil not deferred");
  wd_bark_a: assert property (!module_wd_kick ##1 module_wd_bark |-> wd_cnt == 32'h0 ##1
    !module_wd_bark) else $error("module watchdog pulse wrong");
  chk_sum_a: assert property (chk_valid && !chk_clear |=> chk_sum ==
    8'($past(chk_sum) + $past(chk_char))) else $error("checksum sum wrong");
  read_back_a: assert property (rd_req |=> rd_valid && rd_data == $past(count[rd_chan]))
    else $error("read answer missing");
endmodule

// >>> include/mmc_pkg.sv
// shared constants and carriers for the four-channel counter configuration block
package mmc_pkg;
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_OVERSAMPLE = 16;
  localparam int MODULE_WD_MS = 1600;
  localparam int MODULE_WD_CYCLES = MODULE_WD_MS * (CLK_HZ / 1000);
  localparam int COMM_TICK_MS = 100;
  localparam int COMM_TICK_CYCLES = COMM_TICK_MS * (CLK_HZ / 1000);
  localparam int NUM_CH = 4;
  // baud codes
  localparam logic [5:0] BAUD_MIN = 6'h03;
  localparam logic [5:0] BAUD_MAX = 6'h0a;
  localparam logic [5:0] BAUD_9600 = 6'h06;
  // character formats
  localparam logic [1:0] FMT_NONE_ONE = 2'h0;
  localparam logic [1:0] FMT_NONE_TWO = 2'h1;
  localparam logic [1:0] FMT_EVEN_ONE = 2'h2;
  localparam logic [1:0] FMT_ODD_ONE = 2'h3;
  // input type codes
  localparam logic [7:0] TYPE_UP = 8'h50;
  localparam logic [7:0] TYPE_FREQ = 8'h51;
  localparam logic [7:0] TYPE_UPDOWN = 8'h54;
  localparam logic [7:0] TYPE_PDIR = 8'h55;
  localparam logic [7:0] TYPE_QUAD = 8'h56;
  // report formats
  localparam logic [1:0] REPORT_ENG = 2'h0;
  localparam logic [1:0] REPORT_HEX = 2'h2;
  // configuration selectors
  localparam logic [2:0] SEL_ADDR = 3'h0;
  localparam logic [2:0] SEL_LINE = 3'h1;
  localparam logic [2:0] SEL_FORMAT = 3'h2;
  localparam logic [2:0] SEL_TYPE = 3'h3;
  localparam logic [2:0] SEL_COIL = 3'h4;
  localparam logic [2:0] SEL_PROTO = 3'h5;
  localparam logic [2:0] SEL_COMM_WD = 3'h6;
  // factory and init-mode values
  localparam logic [7:0] DEFAULT_ADDR = 8'h01;
  localparam logic [7:0] INIT_ADDR = 8'h00;
  localparam logic [7:0] DEFAULT_COMM_WD = 8'h00;

  typedef struct packed {
    logic [1:0] char_fmt;
    logic [5:0] baud;
  } line_setting_s;

  typedef struct packed {
    logic rsv_hi;
    logic cs;
    logic [3:0] rsv_lo;
    logic [1:0] report_format_field;
  } output_format_s;

  typedef struct packed {
    logic [7:0] addr;
    line_setting_s line_setting_byte;
    output_format_s output_format_byte;
    logic [7:0] input_type_code;
    logic modbus;
    logic [7:0] comm_wd;
  } stored_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    line_setting_s line;
    logic cs;
    logic modbus;
  } comm_cfg_s;

  localparam line_setting_s DEFAULT_LINE = '{char_fmt: FMT_NONE_ONE, baud: BAUD_9600};
  localparam output_format_s DEFAULT_FORMAT = '{rsv_hi: 1'b0, cs: 1'b0, rsv_lo: 4'h0,
    report_format_field: REPORT_HEX};
endpackage

// >>> verif/host_model.sv
// host-side model: configuration writes and channel reads
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_sys,
  // requests toward the device
  output logic cfg_wr,
  output logic [2:0] cfg_sel,
  output logic [7:0] cfg_data,
  output logic rd_req,
  output logic [1:0] rd_chan,
  // answers from the device
  input wire logic cfg_ack,
  input wire logic cfg_err,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data
);
  // idle at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_sel = 3'h7;
    cfg_data = 8'h00;
    rd_req = 1'b0;
    rd_chan = 2'h0;
  end
  // one write; released data turns to its inverse so stale values never look valid
  task automatic write_cfg(input logic [2:0] sel, input logic [7:0] d,
                           output logic [1:0] resp);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_sel <= sel;
    cfg_data <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_sel <= ~sel;
    cfg_data <= ~d;
    #1 resp = {cfg_ack, cfg_err};
  endtask
  // one channel read; answer one cycle after the request is driven
  task automatic read_chan(input logic [1:0] ch, output logic v, output logic [31:0] d);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_chan <= ch;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    rd_chan <= ~ch;
    #1 v = rd_valid;
    d = rd_data;
  endtask
endmodule

// >>> verif/test_multi_mode_counter_config.sv
// self-checking bench for the four-channel counter configuration block
`timescale 1ns/1ps
module test_multi_mode_counter_config;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic init_n = 1'b1;
  logic init_sw = 1'b0;
  logic fl = 1'b1;
  logic cfg_wr, cfg_ack, cfg_err, rd_req, rd_valid, init_mode;
  logic par_en, par_odd, two_stop, rep_hex, bark, comm_exp, baud_tick;
  logic [2:0] cfg_sel;
  logic [7:0] cfg_data, chk_sum, chk_hi, chk_lo;
  logic [1:0] rd_chan;
  logic [31:0] rd_data;
  mmc_pkg::stored_cfg_s st;
  mmc_pkg::comm_cfg_s act;
  logic [3:0] ch_a = 4'hf;
  logic [3:0] ch_b = 4'hf;
  logic [3:0] clr = 4'h0;
  logic kick = 1'b1;
  logic act_in = 1'b1;
  logic chk_clr = 1'b0;
  logic chk_v = 1'b0;
  logic [7:0] chk_char = 8'h00;
  logic [7:0] types [5] = '{8'h50, 8'h51, 8'h54, 8'h55, 8'h56};
  logic [7:0] msg [4] = '{8'h24, 8'h30, 8'h31, 8'h32};
  int n_errors = 0;
  int cmp_count = 0;
  int k;

  // small watchdog counts keep the run short
  multi_mode_counter_config #(.MODULE_WD_CYCLES(50), .COMM_TICK_CYCLES(10))
      i_multi_mode_counter_config (
    .clk_sys(clk_sys), .rst_n(rst_n), .init_n(init_n), .init_switch(init_sw),
    .factory_load(fl), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
    .cfg_ack(cfg_ack), .cfg_err(cfg_err), .stored_cfg(st), .active_cfg(act),
    .init_mode(init_mode), .parity_en(par_en), .parity_odd(par_odd),
    .two_stop(two_stop), .baud_tick(baud_tick), .report_hex(rep_hex),
    .channel_a_input(ch_a), .channel_b_input(ch_b), .count_clear(clr),
    .rd_req(rd_req), .rd_chan(rd_chan), .rd_valid(rd_valid), .rd_data(rd_data),
    .module_wd_kick(kick), .module_wd_bark(bark), .comm_activity(act_in),
    .comm_wd_expired(comm_exp), .chk_clear(chk_clr), .chk_valid(chk_v),
    .chk_char(chk_char), .chk_sum(chk_sum), .chk_hi_char(chk_hi), .chk_lo_char(chk_lo));

  host_model i_host_model (
    .clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
    .rd_req(rd_req), .rd_chan(rd_chan), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // exp is {ack, err}
  task automatic cfg(input logic [2:0] sel, input logic [7:0] d, input logic [1:0] exp);
    logic [1:0] r;
    i_host_model.write_cfg(sel, d, r);
    check({30'h0, r}, {30'h0, exp});
  endtask

  // init strap is held past the first edge after release, where it is sampled
  task automatic do_reset(input logic f, input logic ini);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    fl <= f;
    init_n <= ini;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    init_n <= 1'b1;
    init_sw <= 1'b0;
    #1;
  endtask

  task automatic step(input logic a, input logic b);
    @(posedge clk_sys);
    ch_a[0] <= a;
    ch_b[0] <= b;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic expect_count(input logic [31:0] exp);
    logic v;
    logic [31:0] d;
    i_host_model.read_chan(2'h0, v, d);
    check({31'h0, v}, 32'h1);
    check(d, exp);
  endtask

  task automatic clear0;
    @(posedge clk_sys);
    clr <= 4'h1;
    repeat (2) @(posedge clk_sys);
    clr <= 4'h0;
  endtask

  // cycles between two oversample ticks, against the rate the active baud code gives
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    while (baud_tick !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    while (baud_tick !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_sys) #1;
    end
    check(n + 1, exp);
  endtask

  // hang guard
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    do_reset(1'b1, 1'b1);
    check({24'h0, st.addr}, 32'h01);
    check({24'h0, st.input_type_code}, 32'h50);
    check({24'h0, st.line_setting_byte}, 32'h06);
    check({14'h0, act}, {14'h0, 8'h01, 8'h06, 2'b01});
    check({30'h0, init_mode, comm_exp}, 32'h0);
    tick_gap(mmc_pkg::CLK_HZ / (mmc_pkg::BAUD_OVERSAMPLE * 9600));
    // factory type counts A falls upward
    clear0();
    for (k = 0; k < 3; k++) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
    end
    expect_count(32'h3);
    // every baud and format code, and the codes just outside
    for (k = 3; k <= 10; k++) cfg(mmc_pkg::SEL_LINE, 8'(k), 2'b10);
    cfg(mmc_pkg::SEL_LINE, 8'h02, 2'b01);
    cfg(mmc_pkg::SEL_LINE, 8'h0b, 2'b01);
    for (k = 0; k < 4; k++) cfg(mmc_pkg::SEL_LINE, {2'(k), 6'h06}, 2'b10);
    check({24'h0, st.line_setting_byte}, 32'hc6);
    check({24'h0, act.line}, 32'h06);
    for (k = 0; k < 5; k++) cfg(mmc_pkg::SEL_TYPE, types[k], 2'b10);
    cfg(mmc_pkg::SEL_TYPE, 8'h52, 2'b01);
    // report format against type, reserved bits, checksum bit
    cfg(mmc_pkg::SEL_FORMAT, 8'h00, 2'b01);
    cfg(mmc_pkg::SEL_FORMAT, 8'h06, 2'b01);
    cfg(mmc_pkg::SEL_TYPE, 8'h51, 2'b10);
    cfg(mmc_pkg::SEL_FORMAT, 8'h00, 2'b10);
    repeat (2) @(posedge clk_sys);
    #1 check({31'h0, rep_hex}, 32'h0);
    cfg(mmc_pkg::SEL_TYPE, 8'h50, 2'b01);
    cfg(mmc_pkg::SEL_FORMAT, 8'h42, 2'b10);
    repeat (2) @(posedge clk_sys);
    #1 check({31'h0, rep_hex}, 32'h1);
    check({24'h0, st.output_format_byte}, 32'h42);
    // up/down, both falls together cancel, then wrap below zero
    cfg(mmc_pkg::SEL_TYPE, 8'h54, 2'b10);
    clear0();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b1);
    expect_count(32'h1);
    for (k = 0; k < 2; k++) begin
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
    end
    expect_count(32'hffffffff);
    // pulse/direction: two up, three down
    cfg(mmc_pkg::SEL_TYPE, 8'h55, 2'b10);
    clear0();
    for (k = 0; k < 2; k++) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
    end
    step(1'b1, 1'b0);
    for (k = 0; k < 3; k++) begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
    end
    expect_count(32'hffffffff);
    // quadrature: two cycles with A leading, three with A lagging
    cfg(mmc_pkg::SEL_TYPE, 8'h56, 2'b10);
    step(1'b0, 1'b0);
    clear0();
    for (k = 0; k < 2; k++) begin
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
    end
    expect_count(32'h2);
    for (k = 0; k < 3; k++) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
    expect_count(32'hffffffff);
    // protocol changes wait for power-on
    cfg(mmc_pkg::SEL_PROTO, 8'h01, 2'b01);
    cfg(mmc_pkg::SEL_COIL, 8'h00, 2'b10);
    check({30'h0, st.modbus, act.modbus}, 32'h1);
    cfg(mmc_pkg::SEL_ADDR, 8'h12, 2'b10);
    cfg(mmc_pkg::SEL_LINE, 8'h87, 2'b10);
    // checksum of a short command string
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      chk_v <= 1'b1;
      chk_clr <= (k == 0);
      chk_char <= msg[k];
    end
    @(posedge clk_sys);
    chk_v <= 1'b0;
    #1 check({8'h0, chk_sum, chk_hi, chk_lo}, 32'h00b74237);
    // module watchdog barks when kicks stop
    @(posedge clk_sys);
    kick <= 1'b0;
    for (k = 0; k < 60 && bark !== 1'b1; k++) @(posedge clk_sys) #1;
    check({31'h0, bark}, 32'h1);
    check(32'(k), 32'd50);
    @(posedge clk_sys);
    kick <= 1'b1;
    // comm watchdog expires after one tick of silence, clears on traffic
    cfg(mmc_pkg::SEL_COMM_WD, 8'h01, 2'b10);
    @(posedge clk_sys);
    act_in <= 1'b0;
    for (k = 0; k < 40 && comm_exp !== 1'b1; k++) @(posedge clk_sys) #1;
    check({31'h0, comm_exp}, 32'h1);
    @(posedge clk_sys);
    act_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check({31'h0, comm_exp}, 32'h0);
    // stored settings go live after a power-on
    do_reset(1'b0, 1'b1);
    check({14'h0, act}, {14'h0, 8'h12, 8'h87, 2'b10});
    check({29'h0, par_en, par_odd, two_stop}, 32'h4);
    tick_gap(mmc_pkg::CLK_HZ / (mmc_pkg::BAUD_OVERSAMPLE * 19200));
    // init strap forces fixed settings and allows protocol select
    do_reset(1'b0, 1'b0);
    check({13'h0, init_mode, act}, {13'h0, 1'b1, 8'h00, 8'h06, 2'b00});
    cfg(mmc_pkg::SEL_PROTO, 8'h01, 2'b10);
    check({31'h0, st.modbus}, 32'h1);
    init_sw <= 1'b1;
    do_reset(1'b0, 1'b1);
    check({31'h0, init_mode}, 32'h1);
    close_out();
  end
endmodule
